//--- dv/fpt_lane_sink.sv
// Purpose: Far-end line receiver that samples the four lanes once per bit period.
// Assumes: The lane register settles on the strobe edge and is read one clock later.
// Notes: It only listens, and it counts enable-mismatch and balance faults on the tone lanes for the bench.
`timescale 1ns/100ps
module fpt_lane_sink
    import fpt_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Lane drive.
    input wire logic bit_strobe,
    input wire fpt_lane_s pair_lane
);
    logic strobe_d = 1'b0;
    logic [3:0] en = 4'h0;
    logic [3:0] lvl = 4'h0;
    logic [31:0] hist3 = 32'h0;
    logic [31:0] hist2 = 32'h0;
    int n_bits = 0;
    int bal3 = 0;
    int bal2 = 0;
    int faults = 0;
    wire logic [3:0] den = pair_lane.drive_en;
    wire logic [3:0] dlv = pair_lane.level;
    wire logic tone_now = den[3] && !den[0];

    always @(posedge aclk) begin
        strobe_d <= bit_strobe && aresetn;
        if (strobe_d) begin
            n_bits <= n_bits + 1;
            en <= den;
            lvl <= dlv;
            hist3 <= {hist3[30:0], dlv[3]};
            hist2 <= {hist2[30:0], dlv[2]};
            bal3 <= tone_now ? bal3 + (dlv[3] ? 1 : -1) : 0;
            bal2 <= tone_now ? bal2 + (dlv[2] ? 1 : -1) : 0;
            // Leaving a tone in mid-half would leave the line charged, so it is a fault.
            if (den[3] !== den[2] || (en == 4'hC && den != 4'hC && (bal3 != 0 || bal2 != 0)))
                faults <= faults + 1;
        end
    end
endmodule

//--- dv/fpt_lane_tx_tb_top.sv
// Purpose: Self-checking bench for the four-pair transmit lane block.
// Assumes: Software stands in for the upper sublayer through the control register.
// Notes: Read data and write responses are checked from queues of expectations.
`timescale 1ns/100ps
`define CHK(g, e) chk(40'(g), 40'(e))
module fpt_lane_tx_tb_top
    import fpt_pkg::*;
;
    localparam logic [31:0] T_ONE = 32'hFF00_00FF;
    localparam logic [31:0] T_TWO = 32'hF00F_F00F;
    localparam int LIMIT = 40000;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    fpt_lane_s pair_lane;
    logic bit_strobe;
    logic [3:0] link_type_code;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [3:0] d;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int mark = 0;
    int k = 0;

    always #2.5 aclk = ~aclk;

    fpt_lane_tx fpt_lane_tx_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .pair_lane(pair_lane), .bit_strobe(bit_strobe), .link_type_code(link_type_code)
    );

    fpt_lane_sink fpt_lane_sink_i (
        .aclk(aclk), .aresetn(aresetn), .bit_strobe(bit_strobe), .pair_lane(pair_lane)
    );

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t mismatch got %0h expected %0h", $time, g, e);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask

    // Bit counting starts before the clock edge on which the request is raised, so a measured delay is never short.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        bq.push_back(r);
        mark = fpt_lane_sink_i.n_bits;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_bit();
        int n0;
        n0 = fpt_lane_sink_i.n_bits;
        while (fpt_lane_sink_i.n_bits == n0)
            @(negedge aclk);
    endtask

    // Waits, at most 40 bit periods, for the masked enables and levels to match.
    task automatic wait_ln(input logic [7:0] w, input logic [7:0] m, output int n);
        @(negedge aclk);
        while ((({fpt_lane_sink_i.en, fpt_lane_sink_i.lvl} & m) !== w)
               && (fpt_lane_sink_i.n_bits - mark < 40))
            wait_bit();
        n = fpt_lane_sink_i.n_bits - mark;
    endtask

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
            `CHK({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            `CHK(s_axi_bresp, bq.pop_front());
    end

    always @(posedge aclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        void'($urandom(32'h25900805));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        `CHK(link_type_code, LINK_TYPE_CODE);
        axi_read(REG_CTRL, {RESP_OKAY, CTRL_RESET});
        axi_read(REG_CONFIG, {RESP_OKAY, 28'h0, LINK_TYPE_CODE});
        axi_read(8'h10, {RESP_SLVERR, 32'h0});
        axi_write(8'h10, 32'h0, RESP_SLVERR);
        `CHK(fpt_lane_sink_i.en, 4'h0);
        done("reset");
        // Every tone pair from silence, left again through both silence codes.
        for (int c = 1; c <= 4; c++) begin
            axi_write(REG_CTRL, 32'h30 | c, RESP_OKAY);
            wait_ln(8'hC0, 8'hF0, k);
            `CHK(k >= 2 && k <= 8, 1'b1);
            repeat (31) wait_bit();
            `CHK(fpt_lane_sink_i.hist3, (c == 2 || c == 4) ? T_TWO : T_ONE);
            `CHK(fpt_lane_sink_i.hist2, (c >= 3) ? T_TWO : T_ONE);
            `CHK(fpt_lane_sink_i.en, 4'hC);
            axi_write(REG_CTRL, (c % 2) ? 32'h30 : 32'h37, RESP_OKAY);
            wait_ln(8'h00, 8'hF0, k);
            `CHK(k <= 20, 1'b1);
        end
        done("tones");
        // Reserved codes must leave tone two running on both lanes.
        axi_write(REG_CTRL, 32'h34, RESP_OKAY);
        wait_ln(8'hC0, 8'hF0, k);
        axi_write(REG_CTRL, 32'h35, RESP_OKAY);
        axi_write(REG_CTRL, 32'h36, RESP_OKAY);
        repeat (40) wait_bit();
        `CHK(fpt_lane_sink_i.hist3[31:16], fpt_lane_sink_i.hist3[15:0]);
        `CHK(fpt_lane_sink_i.hist2[31:16], fpt_lane_sink_i.hist2[15:0]);
        axi_write(REG_CTRL, 32'h31, RESP_OKAY);
        repeat (48) wait_bit();
        `CHK(fpt_lane_sink_i.hist3[31:16], {~fpt_lane_sink_i.hist3[15:0]});
        done("switch");
        d = 4'($urandom);
        axi_write(REG_TDATA, {28'h0, d}, RESP_OKAY);
        axi_write(REG_CTRL, 32'h24, RESP_OKAY);
        wait_ln({4'hF, d[0], d[1], d[2], d[3]}, 8'hFF, k);
        `CHK(k <= 20, 1'b1);
        axi_write(REG_TDATA, {28'h0, ~d}, RESP_OKAY);
        wait_ln({4'hF, ~d[0], ~d[1], ~d[2], ~d[3]}, 8'hFF, k);
        `CHK(k >= 2 && k <= 8, 1'b1);
        axi_write(REG_CTRL, 32'h21, RESP_OKAY);
        repeat (24) wait_bit();
        `CHK({fpt_lane_sink_i.en, fpt_lane_sink_i.lvl}, {4'hF, ~d[0], ~d[1], ~d[2], ~d[3]});
        axi_write(REG_CTRL, 32'h30, RESP_OKAY);
        wait_ln(8'h00, 8'hF0, k);
        `CHK(k <= 4, 1'b1);
        done("data");
        axi_write(REG_CTRL, 32'h34, RESP_OKAY);
        wait_ln(8'hC0, 8'hF0, k);
        axi_write(REG_CTRL, 32'h14, RESP_OKAY);
        wait_ln(8'h00, 8'hF0, k);
        `CHK(k <= 20, 1'b1);
        repeat (16) wait_bit();
        `CHK(fpt_lane_sink_i.en, 4'h0);
        axi_write(REG_CTRL, 32'h34, RESP_OKAY);
        wait_ln(8'hC0, 8'hF0, k);
        `CHK(k >= 2 && k <= 8, 1'b1);
        `CHK(fpt_lane_sink_i.faults, 0);
        done("receive gate");
        close_out();
    end
endmodule

//--- rtl/fpt_lane_tx.sv
// Purpose: Transmit side of a four-pair lane sublayer with AXI4-Lite control.
// Assumes: Bit period is one enable pulse every BIT_DIV clock cycles.
// Notes: Software stands in for the upper sublayer through the control register.
`timescale 1ns/100ps

// Contract
// (R1) Each lane bit is NRZ: one drives high level, zero drives low level.
// (R2) Four data bits go out in parallel, one per lane, at lane rate.
// (R3) Data bit 0 goes to lane 3, bit 3 to lane 0.
// (R4) Data latency is between 2 and 8 bit periods.
// (R5) Tones on lanes 3 and 2 follow control state, synchronous to the clock.
// (R6) Tone one alternates 16-bit halves FF00 and 00FF.
// (R7) Tone two alternates 8-bit halves F0 and 0F.
// (R8) Control codes pick tone pairs; 000 and 111 silence, 101 110 reserved.
// (R9) With both gates idle, lanes 1 and 0 stay silent.
// (R10) A tone after silence starts with its a half.
// (R11) An a half is always followed by a b half, and back.
// (R12) Tone switches happen only on whole half-pattern boundaries on both lanes.
// (R13) Silence from tone starts at a boundary, same bit on both lanes.
// (R14) From silence, first tone bit leaves 2 to 8 bit periods after state.
// (R15) Tone change or silence takes effect within 20 bit periods.
// (R16) Transmit gate ends current halves, then data within 20 bit periods.
// (R17) At most 20 leading preamble bits are dropped per lane.
// (R18) No tones while transmit gate stays active; state may still change.
// (R19) After the last data bit, go straight to tone or silence.
// (R20) Receive gate ends halves, then all lanes silent within 20 bit periods.
// (R21) After receive gate drops, tones resume 2 to 8 bit periods later.
// (R22) Link-type code output shows 0001.
// (R23) Transmit gate is active low, changed on clock edges by upper layer.
// (R24) The upper layer supplies the transmit clock for the interface.
// (R25) Bit-period limits are counted in bit enables with per-lane positions.
module fpt_lane_tx
    import fpt_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Lane drive.
    output fpt_lane_s pair_lane,
    // Bit period strobe and link type.
    output logic bit_strobe,
    output logic [3:0] link_type_code
);

    // Control register and data word.
    logic [31:0] ctrl;
    logic [3:0] tdata_word;
    wire logic [2:0] transmit_control_state = ctrl[CTRL_TCS_LSB +: 3];
    wire logic transmit_gate_n = ctrl[CTRL_TXG_BIT];
    wire logic receive_gate_n = ctrl[CTRL_RXG_BIT];

    // Bit-period divider.
    logic [3:0] div_cnt;
    wire logic bit_en = (div_cnt == BIT_DIV_M1);
    assign bit_strobe = bit_en;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= bit_en ? 4'h0 : div_cnt + 4'h1;
        end
    end

    // Sampled interface, one bit period behind the inputs.
    logic [2:0] tcs_q;
    logic txg_q;
    logic rxg_q;
    logic [3:0] data_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tcs_q <= TCS_OFF_LO;
            txg_q <= 1'b1;
            rxg_q <= 1'b1;
            data_q <= '0;
        end else if (bit_en) begin
            tcs_q <= transmit_control_state;
            txg_q <= transmit_gate_n; // [R23]
            rxg_q <= receive_gate_n;
            data_q <= tdata_word;
        end
    end

    function automatic logic tone_valid(input logic [2:0] code);
        tone_valid = (code >= TCS_ONE_ONE) && (code <= TCS_TWO_TWO); // [R8]
    endfunction

    wire logic tcs_tone = tone_valid(tcs_q);
    wire logic tcs_silence = (tcs_q == TCS_OFF_LO) || (tcs_q == TCS_OFF_HI);

    // Mode machine.
    fpt_mode_e mode;
    fpt_mode_e next_mode;
    logic boundary_ok;
    logic start_tone;
    fpt_tone_s st3;
    fpt_tone_s st2;
    logic b3;
    logic b2;
    logic end3;
    logic end2;

    // Code 010 puts tone two on lane 3, 011 on lane 2; reserved codes keep the tone. [R8]
    wire logic want3_two = tcs_tone ? (tcs_q == TCS_ONE_TWO) || (tcs_q == TCS_TWO_TWO)
                                    : st3.tone_two;
    wire logic want2_two = tcs_tone ? (tcs_q == TCS_TWO_ONE) || (tcs_q == TCS_TWO_TWO)
                                    : st2.tone_two;

    // Leaving only when both lanes are about to start a new half keeps the last half whole,
    // so ones and zeros stay balanced on both lanes. [R12] [R13]
    assign boundary_ok = (st3.pos == 4'h0) && (st2.pos == 4'h0);

    always_comb begin
        next_mode = mode;
        start_tone = 1'b0;
        unique case (mode)
            FPT_SILENT: begin
                if (!txg_q) begin
                    next_mode = FPT_DATA; // [R16]
                end else if (rxg_q && tcs_tone) begin
                    next_mode = FPT_TONE; // [R14] [R21]
                    start_tone = 1'b1;
                end
            end
            FPT_TONE: begin
                if (boundary_ok && !txg_q) begin
                    next_mode = FPT_DATA; // [R16] [R17]
                end else if (boundary_ok && (!rxg_q || tcs_silence)) begin
                    next_mode = FPT_SILENT; // [R13] [R15] [R20]
                end else if (boundary_ok && !tcs_tone) begin
                    // Reserved codes hold the tone running but change nothing.
                    next_mode = FPT_TONE;
                end
            end
            FPT_DATA: begin
                if (txg_q) begin
                    // Last data bit already out; next bit is tone or silence. [R19]
                    if (rxg_q && tcs_tone) begin
                        next_mode = FPT_TONE;
                        start_tone = 1'b1;
                    end else begin
                        next_mode = FPT_SILENT;
                    end
                end
            end
            FPT_HOLD: begin
                next_mode = FPT_SILENT;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= FPT_SILENT;
        end else if (bit_en) begin
            mode <= next_mode;
        end
    end

    // Tone lanes run while in tone mode; the tone re-pick happens at half ends.
    wire logic run_tone = (mode == FPT_TONE);

    fpt_tone_lane u_lane3 (
        .aclk(aclk),
        .aresetn(aresetn),
        .bit_en(bit_en),
        .run(run_tone),
        .start(start_tone),
        .want_two(want3_two),
        .state(st3),
        .bit_out(b3),
        .at_end(end3)
    );

    fpt_tone_lane u_lane2 (
        .aclk(aclk),
        .aresetn(aresetn),
        .bit_en(bit_en),
        .run(run_tone),
        .start(start_tone),
        .want_two(want2_two),
        .state(st2),
        .bit_out(b2),
        .at_end(end2)
    );

    // Lane output register; data bits reversed onto lanes. [R3]
    fpt_lane_s next_lane;

    always_comb begin
        next_lane = '0;
        unique case (next_mode)
            FPT_TONE: begin
                // Silence on lanes 1 and 0 during tones. [R9] [R18]
                next_lane.drive_en = 4'b1100;
                next_lane.level = {b3, b2, 2'b00};
            end
            FPT_DATA: begin
                next_lane.drive_en = 4'hF; // [R2]
                next_lane.level = {data_q[0], data_q[1], data_q[2], data_q[3]}; // [R1] [R3] [R4]
            end
            default: begin
                next_lane = '0;
            end
        endcase
        if (start_tone) begin
            next_lane.level = {TONE_ONE_HALF_A[15], TONE_TWO_HALF_A[7], 2'b00};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair_lane <= '0;
        end else if (bit_en) begin
            pair_lane <= next_lane; // [R1] [R5]
        end
    end

    assign link_type_code = LINK_TYPE_CODE; // [R22]

    // AXI4-Lite slave: address and data taken in either order.
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire logic do_write = aw_held && w_held && !s_axi_bvalid;
    wire logic wr_ctrl = (aw_addr == REG_CTRL);
    wire logic wr_tdata = (aw_addr == REG_TDATA);

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            strb_merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
        end
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ctrl || wr_tdata) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            tdata_word <= '0;
        end else if (do_write && wr_ctrl) begin
            ctrl <= strb_merge(ctrl, w_data, w_strb) & 32'h0000_003F;
        end else if (do_write && wr_tdata && w_strb[0]) begin
            tdata_word <= w_data[3:0];
        end
    end

    // Read side: status shows mode and lane drive.
    wire logic [31:0] status_word = {16'h0000, pair_lane, 4'h0, 2'(mode), 2'b00};
    wire logic [7:0] ra = s_axi_araddr;
    wire logic ra_ok = (ra == REG_CTRL) || (ra == REG_STATUS) || (ra == REG_TDATA)
                       || (ra == REG_CONFIG);
    wire logic [31:0] rd_mux = (ra == REG_CTRL) ? ctrl :
                               (ra == REG_STATUS) ? status_word :
                               (ra == REG_TDATA) ? {28'h0, tdata_word} :
                               (ra == REG_CONFIG) ? {28'h0, LINK_TYPE_CODE} : 32'h0;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= ra_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks.
    tone_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_en && start_tone |=> pair_lane.drive_en == 4'b1100 && !st3.half_b) // [R10]
        else $error("Tone did not start on its a half.");
    low_lanes_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode != FPT_DATA |-> pair_lane.drive_en[1:0] == 2'b00) // [R9]
        else $error("Lanes 1 and 0 driven outside data.");
    lanes_together_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pair_lane.drive_en[3] == pair_lane.drive_en[2]) // [R13]
        else $error("Tone lanes enabled apart.");
    tone_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_en && mode == FPT_TONE && next_mode != FPT_TONE |-> st3.pos == 4'h0 && st2.pos == 4'h0) // [R12]
        else $error("Tone left off a half boundary.");
    half_alt_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_en && run_tone && end3 && !start_tone |=> st3.half_b != $past(st3.half_b)) // [R11]
        else $error("Halves did not alternate.");
    lane2_alt_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
        bit_en && run_tone && end2 && !start_tone |=> st2.half_b != $past(st2.half_b))
        else $error("Lane 2 halves did not alternate.");
    data_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mode == FPT_DATA |-> pair_lane.level[3] == $past(data_q[0], BIT_DIV)) // [R3]
        else $error("Data bit 0 not on lane 3.");
    no_tone_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bit_en && mode == FPT_DATA && !txg_q |=> mode == FPT_DATA) // [R18]
        else $error("Tone sent while transmit gate active.");
    link_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
        link_type_code == 4'h1) // [R22]
        else $error("Wrong link-type code.");
    tone_cov: cover property (@(posedge aclk) mode == FPT_TONE);
    data_cov: cover property (@(posedge aclk) mode == FPT_DATA);
    switch_cov: cover property (@(posedge aclk) bit_en && end3 && st3.tone_two != want3_two);

endmodule

//--- rtl/fpt_pkg.sv
// Purpose: Shared constants and types for the four-pair transmit lane block.
// Assumes: One 200 MHz clock; one bit period is one enable pulse from a divider.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package fpt_pkg;

    // Clock and lane timing.
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned LANE_BAUD = 30_000_000;
    localparam int unsigned BIT_DIV = CLK_HZ / LANE_BAUD;
    localparam logic [3:0] BIT_DIV_M1 = 4'(BIT_DIV - 1);

    // Bit-period limits.
    localparam logic [4:0] LAT_MIN_BP = 5'h02;
    localparam logic [4:0] LAT_MAX_BP = 5'h08;
    localparam logic [4:0] SWITCH_MAX_BP = 5'h14;
    localparam logic [4:0] PREAMBLE_DROP_MAX = 5'h14;

    // Tone patterns, first bit in the most significant position.
    localparam logic [15:0] TONE_ONE_HALF_A = 16'hFF00;
    localparam logic [15:0] TONE_ONE_HALF_B = 16'h00FF;
    localparam logic [7:0] TONE_TWO_HALF_A = 8'hF0;
    localparam logic [7:0] TONE_TWO_HALF_B = 8'h0F;
    localparam logic [3:0] TONE_ONE_LEN_M1 = 4'hF;
    localparam logic [3:0] TONE_TWO_LEN_M1 = 4'h7;

    // Transmit control state codes.
    localparam logic [2:0] TCS_OFF_LO = 3'h0;
    localparam logic [2:0] TCS_ONE_ONE = 3'h1;
    localparam logic [2:0] TCS_ONE_TWO = 3'h2;
    localparam logic [2:0] TCS_TWO_ONE = 3'h3;
    localparam logic [2:0] TCS_TWO_TWO = 3'h4;
    localparam logic [2:0] TCS_OFF_HI = 3'h7;

    // Link-type code for the four-pair variant.
    localparam logic [3:0] LINK_TYPE_CODE = 4'h1;

    // Register map.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TDATA = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h0C;
    localparam int unsigned CTRL_TCS_LSB = 0;
    localparam int unsigned CTRL_TXG_BIT = 4;
    localparam int unsigned CTRL_RXG_BIT = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        FPT_SILENT,
        FPT_TONE,
        FPT_DATA,
        FPT_HOLD
    } fpt_mode_e;

    // Lane output group: level and driver enable per lane.
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] drive_en;
    } fpt_lane_s;

    // One tone lane position.
    typedef struct packed {
        logic tone_two;
        logic half_b;
        logic [3:0] pos;
    } fpt_tone_s;

endpackage

//--- rtl/fpt_tone_lane.sv
// Purpose: Per-lane tone generator for one of the two tone lanes.
// Assumes: Advances one bit on each bit enable while run is high.
// Notes: Tone selection is taken only at a half-pattern boundary.
`timescale 1ns/100ps
module fpt_tone_lane
    import fpt_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Control.
    input wire logic bit_en,
    input wire logic run,
    input wire logic start,
    input wire logic want_two,
    // Status.
    output fpt_tone_s state,
    output logic bit_out,
    output logic at_end
);

    fpt_tone_s cur;
    fpt_tone_s next_cur;
    wire logic [3:0] last_pos = cur.tone_two ? TONE_TWO_LEN_M1 : TONE_ONE_LEN_M1;
    wire logic [15:0] pat1 = cur.half_b ? TONE_ONE_HALF_B : TONE_ONE_HALF_A;
    wire logic [7:0] pat2 = cur.half_b ? TONE_TWO_HALF_B : TONE_TWO_HALF_A;

    // Position counter tracks each lane's place in its pattern. [R25]
    assign at_end = (cur.pos == last_pos);
    assign bit_out = cur.tone_two ? pat2[3'(7 - cur.pos)] : pat1[4'(15 - cur.pos)]; // [R6] [R7]
    assign state = cur;

    always_comb begin
        next_cur = cur;
        if (start) begin
            // The first a-half bit leaves together with the start, so count on from the second.
            next_cur = '{tone_two: want_two, half_b: 1'b0, pos: 4'h1}; // [R10]
        end else if (run && at_end) begin
            // Alternate halves and re-pick the tone only here. [R11] [R12]
            next_cur = '{tone_two: want_two, half_b: ~cur.half_b, pos: 4'h0};
        end else if (run) begin
            next_cur.pos = cur.pos + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur <= '0;
        end else if (bit_en) begin
            cur <= next_cur;
        end
    end

endmodule
